// ### design/lmsa_pkg.sv
// Constants for the leg-two monitor and sense amplifier configuration bank
package lmsa_pkg;
	localparam logic [6:0]  ADDR_LEG_B_MON   = 7'h07;
	localparam logic [6:0]  ADDR_SENSE_AMP   = 7'h08;
	localparam logic [15:0] LEG_B_MON_MASK   = 16'h0EEC;
	localparam logic [15:0] SENSE_AMP_MASK   = 16'h6A00;
	localparam logic [15:0] CFG_RESET        = 16'h0000;
	localparam int          THR_LSB          = 9;
	localparam int          BLANK_LSB        = 5;
	localparam int          FILT_LSB         = 2;
	localparam int          GAIN_LSB         = 13;
	localparam int          SHDN_BIT         = 11;
	localparam int          OFFS_BIT         = 9;
	localparam int          FILT_STEP_NS     = 1500;
	localparam int          BLANK_STEP_NS    = 1000;
	localparam int          CLK_PERIOD_NS    = 50;
	localparam logic [7:0]  FILT_STEP_CYC    = 8'(FILT_STEP_NS / CLK_PERIOD_NS);
	localparam logic [7:0]  BLANK_STEP_CYC   = 8'(BLANK_STEP_NS / CLK_PERIOD_NS);
	// Threshold in millivolts per code
	localparam logic [10:0] THR_MV [8]       = '{11'd75, 11'd150, 11'd250, 11'd400,
	                                              11'd600, 11'd800, 11'd1000, 11'd1200};
	// Gain value per code
	localparam logic [6:0]  GAIN_VAL [4]     = '{7'd10, 7'd20, 7'd50, 7'd100};
endpackage

// ### design/lmsa_decode.sv
// Decoder of the leg-two monitor word into analog trim settings
`timescale 1ns/1ps
module lmsa_decode
	import lmsa_pkg::*;
(
	input  wire logic [15:0] mon_word,
	input  wire logic        independent_input_select,
	output logic      [10:0] threshold_mv,
	output logic      [9:0]  blanking_cycles,
	output logic      [9:0]  filter_cycles
);
	import lmsa_pkg::*;
	wire logic [2:0] thr_code   = independent_input_select ? mon_word[THR_LSB +: 3] : 3'h0;
	wire logic [2:0] blank_code = independent_input_select ? mon_word[BLANK_LSB +: 3] : 3'h0;
	wire logic [1:0] filt_code  = independent_input_select ? mon_word[FILT_LSB +: 2] : 2'h0;
	// Code plus one, times the step length in clock cycles
	function automatic logic [9:0] step_cycles(input logic [2:0] code, input logic [7:0] step_len);
		step_cycles = 10'({2'h0, code} + 5'h01) * 10'(step_len);
	endfunction

	// Table lookup and step scaling
	assign threshold_mv    = THR_MV[thr_code];
	assign blanking_cycles = step_cycles(blank_code, BLANK_STEP_CYC);
	assign filter_cycles   = step_cycles({1'b0, filt_code}, FILT_STEP_CYC);
endmodule // lmsa_decode

// ### design/lmsa_bank.sv
// Configuration bank for leg-two drain-source monitor and amplifier one
`timescale 1ns/1ps
module lmsa_bank
	import lmsa_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        wr_en,
	input  wire logic [6:0]  wr_addr,
	input  wire logic [15:0] wr_data,
	input  wire logic [6:0]  rd_addr,
	input  wire logic        independent_input_select,
	output logic      [15:0] rd_data,
	output logic      [15:0] leg_b_monitor_config,
	output logic      [15:0] sense_amp_config,
	output logic      [10:0] drain_source_threshold_leg_b,
	output logic      [9:0]  drain_source_blanking_leg_b,
	output logic      [9:0]  drain_source_filter_leg_b,
	output logic      [6:0]  amp_one_gain,
	output logic             amp_one_enable,
	output logic             amp_one_offset_high
);
	import lmsa_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [15:0] mon_q;
	logic [15:0] mon_d;
	logic [15:0] amp_q;
	logic [15:0] amp_d;
	logic [15:0] rd_q;
	logic [15:0] rd_d;
	logic [10:0] thr_q;
	logic [9:0]  blank_q;
	logic [9:0]  filt_q;
	logic [6:0]  gain_q;
	logic        en_q;
	logic        offs_q;
	logic [10:0] thr_w;
	logic [9:0]  blank_w;
	logic [9:0]  filt_w;
	logic [6:0]  gain_w;
	logic        en_w;
	logic        offs_w;

	// Merge one written word into its stored copy, reserved bits dropped
	function automatic logic [15:0] merge_write
	(
		input logic        hit,
		input logic [15:0] old_word,
		input logic [15:0] new_word,
		input logic [15:0] mask
	);
		merge_write = hit ? (new_word & mask) : old_word;
	endfunction

	// Address match, shared by the write and read decoders
	function automatic logic addr_match(input logic [6:0] addr, input logic [6:0] target);
		addr_match = (addr == target);
	endfunction

	// Write strobes and read selects per word
	wire logic wr_mon = wr_en && addr_match(wr_addr, ADDR_LEG_B_MON);
	wire logic wr_amp = wr_en && addr_match(wr_addr, ADDR_SENSE_AMP);
	wire logic rd_mon = addr_match(rd_addr, ADDR_LEG_B_MON);
	wire logic rd_amp = addr_match(rd_addr, ADDR_SENSE_AMP);

	// Masked write of writable fields only
	assign mon_d = merge_write(wr_mon, mon_q, wr_data, LEG_B_MON_MASK);
	assign amp_d = merge_write(wr_amp, amp_q, wr_data, SENSE_AMP_MASK);

	// Read mux, unmapped address reads zero; a same-cycle write reads back at once
	assign rd_d = rd_mon ? mon_d :
	              rd_amp ? amp_d : 16'h0000;

	// Amplifier one field decode from the next stored word
	assign gain_w = GAIN_VAL[amp_d[GAIN_LSB +: 2]];
	assign en_w   = ~amp_d[SHDN_BIT];
	assign offs_w = amp_d[OFFS_BIT];

	// Monitor decode
	lmsa_decode u_dec
	(
		.mon_word                 (mon_d),
		.independent_input_select (independent_input_select),
		.threshold_mv             (thr_w),
		.blanking_cycles          (blank_w),
		.filter_cycles            (filt_w)
	);

	// Stored words
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			mon_q <= CFG_RESET;
			amp_q <= CFG_RESET;
		end
		else
		begin
			mon_q <= mon_d;
			amp_q <= amp_d;
		end
	end

	// Registered read data
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rd_q <= CFG_RESET;
		else
			rd_q <= rd_d;
	end

	// Leg-two monitor settings, code-0 values out of independent mode
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			thr_q   <= THR_MV[0];
			blank_q <= 10'(BLANK_STEP_CYC);
			filt_q  <= 10'(FILT_STEP_CYC);
		end
		else
		begin
			thr_q   <= thr_w;
			blank_q <= blank_w;
			filt_q  <= filt_w;
		end
	end

	// Amplifier one settings, enabled at lowest gain out of reset
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			gain_q <= GAIN_VAL[0];
			en_q   <= 1'b1;
			offs_q <= 1'b0;
		end
		else
		begin
			gain_q <= gain_w;
			en_q   <= en_w;
			offs_q <= offs_w;
		end
	end

	// Outputs from flops
	assign leg_b_monitor_config         = mon_q;
	assign sense_amp_config             = amp_q;
	assign rd_data                      = rd_q;
	assign drain_source_threshold_leg_b = thr_q;
	assign drain_source_blanking_leg_b  = blank_q;
	assign drain_source_filter_leg_b    = filt_q;
	assign amp_one_gain                 = gain_q;
	assign amp_one_enable               = en_q;
	assign amp_one_offset_high          = offs_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence write_amp_s;
		wr_en && (wr_addr == ADDR_SENSE_AMP);
	endsequence

	thr_decode_a: assert property (@(posedge mclk) disable iff (reset)
		independent_input_select |=> thr_q == THR_MV[mon_q[THR_LSB +: 3]])
		else $error("threshold mismatch");
	mode_gate_a: assert property (@(posedge mclk) disable iff (reset)
		!independent_input_select |=> thr_q == 11'd75 && blank_q == 10'd20 && filt_q == 10'd30)
		else $error("leg-two fields applied outside independent mode");
	blank_time_a: assert property (@(posedge mclk) disable iff (reset)
		independent_input_select |=> blank_q == 10'((mon_q[BLANK_LSB +: 3] + 1) * 20))
		else $error("blanking time wrong");
	filt_time_a: assert property (@(posedge mclk) disable iff (reset)
		independent_input_select |=> filt_q == 10'((mon_q[FILT_LSB +: 2] + 1) * 30))
		else $error("filter time wrong");
	gain_sel_a: assert property (@(posedge mclk) disable iff (reset)
		write_amp_s ##0 (wr_data[14:13] == 2'b11) |=> gain_q == 7'd100)
		else $error("gain code wrong");
	amp_shdn_a: assert property (@(posedge mclk) disable iff (reset)
		write_amp_s |=> en_q == !$past(wr_data[11]))
		else $error("shutdown bit not applied");
	offset_sel_a: assert property (@(posedge mclk) disable iff (reset)
		write_amp_s |=> offs_q == $past(wr_data[9]))
		else $error("offset select not applied");
	reserved_zero_a: assert property (@(posedge mclk) disable iff (reset)
		((mon_q & ~LEG_B_MON_MASK) == 16'h0000) && ((amp_q & ~SENSE_AMP_MASK) == 16'h0000))
		else $error("reserved bit set");
	reset_clear_a: assert property (@(posedge mclk)
		$fell(reset) |-> mon_q == 16'h0000 && amp_q == 16'h0000 && en_q)
		else $error("reset value wrong");

	// Write to the monitor word
	sequence write_mon_s;
		wr_en && (wr_addr == ADDR_LEG_B_MON);
	endsequence

	// Gain code of the incoming word, for the one-cycle-late check
	wire logic [1:0] wr_gain_code = wr_data[GAIN_LSB +: 2];

	// Field, hold and readback checks
	gain_table_a: assert property (@(posedge mclk) disable iff (reset)
		write_amp_s |=> gain_q == GAIN_VAL[$past(wr_gain_code)])
		else $error("gain table lookup wrong");
	amp_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!wr_amp |=> $stable(gain_q) && $stable(en_q) && $stable(offs_q))
		else $error("amplifier settings changed without a write");
	mode_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!wr_mon && $stable(independent_input_select) |=> $stable(thr_q) && $stable(blank_q) && $stable(filt_q))
		else $error("monitor settings changed without cause");
	mon_write_a: assert property (@(posedge mclk) disable iff (reset)
		write_mon_s |=> mon_q == ($past(wr_data) & LEG_B_MON_MASK))
		else $error("monitor word write wrong");
	amp_write_a: assert property (@(posedge mclk) disable iff (reset)
		write_amp_s |=> amp_q == ($past(wr_data) & SENSE_AMP_MASK))
		else $error("amplifier word write wrong");
	word_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!wr_mon && !wr_amp |=> $stable(mon_q) && $stable(amp_q))
		else $error("stored word changed without a write");
	read_mon_a: assert property (@(posedge mclk) disable iff (reset)
		rd_mon |=> rd_data == mon_q)
		else $error("monitor word readback wrong");
	read_amp_a: assert property (@(posedge mclk) disable iff (reset)
		rd_amp |=> rd_data == amp_q)
		else $error("amplifier word readback wrong");
	read_unmapped_a: assert property (@(posedge mclk) disable iff (reset)
		!rd_mon && !rd_amp |=> rd_data == 16'h0000)
		else $error("unmapped address read nonzero");
	reset_decode_a: assert property (@(posedge mclk)
		$fell(reset) |-> thr_q == THR_MV[0] && blank_q == 10'(BLANK_STEP_CYC) && filt_q == 10'(FILT_STEP_CYC)
			&& gain_q == GAIN_VAL[0] && !offs_q && rd_data == 16'h0000)
		else $error("decoded reset value wrong");
endmodule // lmsa_bank

// ### verification/lmsa_host.sv
// Host model issuing whole-word writes and read selects
`timescale 1ns/1ps
module lmsa_host
(
	input  wire logic        mclk,
	output logic             wr_en,
	output logic      [6:0]  wr_addr,
	output logic      [15:0] wr_data,
	output logic      [6:0]  rd_addr
);
	initial {wr_en, wr_addr, wr_data, rd_addr} = '0;
	// One-cycle write pulse, read select on same word
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
	begin
		@(posedge mclk) #1;
		{wr_en, wr_addr, wr_data, rd_addr} = {1'b1, a, d, a};
		@(posedge mclk) #1;
		wr_en = 1'b0;
		wr_data = ~d; // Stale data no longer valid
	end
	endtask
endmodule // lmsa_host

// ### verification/lmsa_bank_tb_top.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module lmsa_bank_tb_top;
	import lmsa_pkg::*;
	logic        mclk = 0, reset = 1, mode = 0, wr_en, en, offs;
	logic [6:0]  wr_addr, rd_addr, gain, a;
	logic [15:0] wr_data, rd_data, mon_w, amp_w, mon_o, amp_o;
	logic [10:0] thr;
	logic [9:0]  blk, flt;
	logic [87:0] q[$];
	int          errors = 0, check_count = 0, seed = 79;
	event        smp;
	lmsa_host host (.mclk, .wr_en, .wr_addr, .wr_data, .rd_addr);
	lmsa_bank uut (.mclk, .reset, .wr_en, .wr_addr, .wr_data, .rd_addr,
		.independent_input_select(mode), .rd_data, .leg_b_monitor_config(mon_o),
		.sense_amp_config(amp_o), .drain_source_threshold_leg_b(thr),
		.drain_source_blanking_leg_b(blk), .drain_source_filter_leg_b(flt),
		.amp_one_gain(gain), .amp_one_enable(en), .amp_one_offset_high(offs));
	// Clock, 50 ns period
	initial forever #25 mclk = ~mclk;
	// Compare one result against its note
	task automatic cmp(input logic [87:0] e, input logic [87:0] g);
	begin
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	end
	endtask
	// Note expected outputs from the model words
	task automatic note(input logic [6:0] ra);
	begin
		q.push_back({ra == ADDR_LEG_B_MON ? mon_w : (ra == ADDR_SENSE_AMP ? amp_w : 16'h0000),
			mode ? THR_MV[mon_w[11:9]] : 11'd75, mode ? 10'(20 * (mon_w[7:5] + 1)) : 10'd20,
			mode ? 10'(30 * (mon_w[3:2] + 1)) : 10'd30, GAIN_VAL[amp_w[14:13]], ~amp_w[11], amp_w[9],
			mon_w, amp_w});
		-> smp;
	end
	endtask
	// Write, update model, note result
	task automatic step(input logic [6:0] wa, input logic [15:0] d);
	begin
		mode = 1'($random(seed));
		host.wr(wa, d);
		if (wa == ADDR_LEG_B_MON) mon_w = d & LEG_B_MON_MASK;
		if (wa == ADDR_SENSE_AMP) amp_w = d & SENSE_AMP_MASK;
		note(wa);
	end
	endtask
	// All watched outputs in note order
	wire logic [87:0] got = {rd_data, thr, blk, flt, gain, en, offs, mon_o, amp_o};
	// Oldest note against current outputs
	always @(smp)
	begin
		cmp(q.pop_front(), got);
	end
	// Verdict and end of run
	task automatic finish_test();
	begin
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		mon_w = CFG_RESET;
		amp_w = CFG_RESET;
		repeat (2) @(posedge mclk);
		#1 reset = 0;
		note(7'h00);
		$display("reset test done");
		step(ADDR_LEG_B_MON, 16'hFFFF);
		step(ADDR_SENSE_AMP, 16'hFFFF);
		for (int i = 0; i < 150; i++)
		begin
			a = 7'h07 + 7'(($random(seed) & 32'hFF) % 3);
			step(a, 16'($random(seed)));
		end
		$display("random write test done");
		// Reset again in mid-run with words stored
		@(posedge mclk) #1 reset = 1;
		repeat (2) @(posedge mclk);
		#1 reset = 0;
		mon_w = CFG_RESET;
		amp_w = CFG_RESET;
		note(7'h00);
		step(ADDR_SENSE_AMP, 16'h6A00);
		$display("mid-run reset test done");
		@(posedge mclk);
		finish_test();
	end
	// Watchdog against a hang
	initial
	begin
		#100000;
		errors++;
		finish_test();
	end
endmodule // lmsa_bank_tb_top
